// ### tme_pkg.sv
// Shared constants and types for the table move engine
package tme_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 16;
   localparam int CNT_W = 8;
   // Highest register reachable by non-extended functions without the option
   localparam logic [ADDR_W-1:0] REG_LIMIT = 16'h0400;
   // First word of the discrete I/O image in the unified word space
   localparam logic [ADDR_W-1:0] IO_WORD_BASE = 16'hC000;
   // Discrete points per I/O word, as a shift
   localparam int IO_BITS_SHIFT = 4;
   localparam logic [ADDR_W-1:0] IO_FIRST_BIT = 16'h0001;
   localparam logic [WORD_W-1:0] PTR_FIRST = 16'h0001;
   localparam logic [WORD_W-1:0] PTR_STEP = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   // Newest firmware revision that lacks indirect referencing
   localparam int FW_NO_INDIRECT = 104;
   localparam int FIFO_DEPTH = 4;
   localparam time CLK_PERIOD_NS = 40;

   // Function selected for the scan
   typedef enum logic [1:0]
   {
      TME_FN_TBL_TO_TARGET_WORD_REF,
      TME_FN_TBL_TO_TBL,
      TME_FN_EXTENDED,
      TME_FN_NONE
   } tme_fn_e;

   typedef enum
   {
      TME_IDLE,
      TME_CNT_RD,
      TME_PTR_RD,
      TME_PTR_WR,
      TME_SEL,
      TME_IND_A,
      TME_SRC_RD,
      TME_IND_B,
      TME_DST_WR,
      TME_FIN
   } tme_state_e;
endpackage : tme_pkg

// ### tme_stream_if.sv
// Word stream between the engine and its staging FIFO
`timescale 1ns/100ps
interface tme_stream_if #(parameter int WIDTH = 16);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   modport eng (output in_valid, output in_data, input in_ready,
      input out_valid, input out_data, output out_ready);
   modport buf_side (input in_valid, input in_data, output in_ready,
      output out_valid, output out_data, input out_ready);
endinterface : tme_stream_if

// ### tme_fifo.sv
// Staging FIFO for words read from the source table
`timescale 1ns/100ps
module tme_fifo
   import tme_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clock,
   input wire logic reset_n,
   tme_stream_if.buf_side st
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] fill_reg;
   wire push = st.in_valid && st.in_ready;
   wire pop = st.out_valid && st.out_ready;

   // Honest full and empty from the fill count
   assign st.in_ready = (fill_reg != DEPTH_C);
   assign st.out_valid = (fill_reg != '0);
   assign st.out_data = mem_reg[rd_ptr_reg];

   // Storage write
   always_ff @(posedge clock)
   begin
      if (push) mem_reg[wr_ptr_reg] <= st.in_data;
   end

   // Pointers and fill level
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fill_reg <= '0;
      end
      else
      begin
         if (push) wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         fill_reg <= fill_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : tme_fifo

// ### tme_addr.sv
// Reference to word-address translation for register and I/O space
`timescale 1ns/100ps
module tme_addr
   import tme_pkg::*;
(
   input wire logic [ADDR_W-1:0] ref_base,
   input wire logic ref_is_io,
   input wire logic [WORD_W-1:0] word_off,
   output logic [ADDR_W-1:0] word_addr,
   output logic above_limit
);
   // I/O base is a 1-based point number on a 16-point word boundary
   wire [ADDR_W-1:0] io_word = IO_WORD_BASE + ((ref_base - IO_FIRST_BIT) >> IO_BITS_SHIFT);
   // Offset of n words is n times 16 points in I/O space
   wire [ADDR_W-1:0] io_addr = io_word + word_off;
   wire [ADDR_W-1:0] reg_addr = ref_base + word_off;

   assign word_addr = ref_is_io ? io_addr : reg_addr;
   assign above_limit = !ref_is_io && (reg_addr > REG_LIMIT);
endmodule : tme_addr

// ### tme_engine.sv
// Table move engine: pointer copy, table copy and extended table copy
//
// What this block does
// - Each enabled pointer-copy scan adds one to the stored pointer before choosing entry.
// - Pointer copy gives power flow when incremented pointer equals table length.
// - Source word is pointer location plus pointer value; value one is next word.
// - After the last entry, the next enabled scan restarts at the first entry.
// - Each enabled scan overwrites the single destination with the next entry.
// - Table copy uses no pointer and copies every word each enabled scan.
// - Table and extended copies give power flow on every enabled scan.
// - Table copy takes constant length 1..255 between register and I/O space.
// - Without the option only extended copy reaches registers above 1024.
// - Extended copy length is a constant or the content of a memory word.
// - Indirect tables hold register addresses of the data; needs newer firmware.
// - All moves are in 16-bit words.
// - Source words stay unchanged; destination words are overwritten.
// - An I/O table entry lies sixteen points per pointer step from the base.
`timescale 1ns/100ps
module tme_engine
   import tme_pkg::*;
#(
   parameter int FW_REV = 105,
   parameter int BUF_DEPTH = FIFO_DEPTH
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic scan_tick,
   input wire logic rung_enable,
   input wire logic [1:0] func_sel,
   input wire logic expanded_opt,
   input wire logic [ADDR_W-1:0] source_block_ref,
   input wire logic source_is_io,
   input wire logic [ADDR_W-1:0] target_block_ref,
   input wire logic target_is_io,
   input wire logic [ADDR_W-1:0] target_word_ref,
   input wire logic target_word_is_io,
   input wire logic [CNT_W-1:0] word_count,
   input wire logic count_from_mem,
   input wire logic [ADDR_W-1:0] count_ref,
   input wire logic count_is_io,
   input wire logic indirect_source,
   input wire logic indirect_target,
   output logic mem_req,
   output logic mem_we,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [WORD_W-1:0] mem_wdata,
   input wire logic [WORD_W-1:0] mem_rdata,
   input wire logic mem_ack,
   output logic power_flow,
   output logic scan_done,
   output logic busy,
   output logic access_fault
);
   localparam bit IND_OK = (FW_REV > FW_NO_INDIRECT);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   tme_state_e state_reg, state_next;
   tme_fn_e fn_reg;
   logic [ADDR_W-1:0] src_ref_reg, dst_ref_reg;
   logic src_io_reg, dst_io_reg, ind_a_reg, ind_b_reg;
   logic [CNT_W-1:0] len_reg, rd_idx_reg, wr_idx_reg;
   logic [WORD_W-1:0] ptr_reg;
   logic [ADDR_W-1:0] ind_addr_reg;
   logic mem_req_reg, mem_we_reg, power_flow_reg, scan_done_reg, fault_reg;
   logic [ADDR_W-1:0] mem_addr_reg;
   logic [WORD_W-1:0] mem_wdata_reg;
   logic [ADDR_W-1:0] xl_base;
   logic xl_io;
   logic [WORD_W-1:0] xl_off;
   logic [ADDR_W-1:0] xl_addr;
   logic xl_high;
   logic [ADDR_W-1:0] acc_addr;
   logic acc_we;
   logic [WORD_W-1:0] acc_wdata;

   tme_stream_if #(.WIDTH(WORD_W)) st ();

   ////////////////////////////////////////////////////////////////////////////
   // Staging buffer and address translation
   tme_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset_n(reset_n),
      .st(st.buf_side)
   );

   tme_addr u_addr (
      .ref_base(xl_base),
      .ref_is_io(xl_io),
      .word_off(xl_off),
      .word_addr(xl_addr),
      .above_limit(xl_high)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Scan start decode
   wire start = scan_tick && rung_enable && (state_reg == TME_IDLE);
   wire fn_valid = (tme_fn_e'(func_sel) != TME_FN_NONE);
   wire is_ext = (fn_reg == TME_FN_EXTENDED);
   wire is_t2d = (fn_reg == TME_FN_TBL_TO_TARGET_WORD_REF);
   wire high_ok = expanded_opt || is_ext;
   wire issue = !mem_req_reg;
   wire done_acc = mem_req_reg && mem_ack;

   // Pointer step with wrap to the first entry
   wire [WORD_W-1:0] ptr_inc = mem_rdata + PTR_STEP;
   wire ptr_wrap = (ptr_inc == '0) || (ptr_inc > WORD_W'(len_reg));
   wire [WORD_W-1:0] ptr_new = ptr_wrap ? PTR_FIRST : ptr_inc;

   // Transfer progress
   wire reads_left = (rd_idx_reg != len_reg);
   wire writes_left = (wr_idx_reg != len_reg);
   wire can_read = reads_left && st.in_ready;
   wire [CNT_W-1:0] mem_count = mem_rdata[CNT_W-1:0];

   // Source offset: pointer value for pointer copy, running index otherwise
   wire [WORD_W-1:0] src_off = is_t2d ? ptr_reg : WORD_W'(rd_idx_reg);
   // Single destination word for pointer copy
   wire [WORD_W-1:0] dst_off = is_t2d ? '0 : WORD_W'(wr_idx_reg);
   wire [WORD_W-1:0] ind_src_off = WORD_W'(rd_idx_reg);
   wire [WORD_W-1:0] ind_dst_off = WORD_W'(wr_idx_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Translator input selection by state
   always_comb
   begin
      xl_base = src_ref_reg;
      xl_io = src_io_reg;
      xl_off = '0;
      unique case (state_reg)
         TME_CNT_RD:
         begin
            xl_base = count_ref;
            xl_io = count_is_io;
         end
         TME_IND_A: xl_off = ind_src_off;
         TME_SRC_RD: xl_off = src_off;
         TME_IND_B:
         begin
            xl_base = dst_ref_reg;
            xl_io = dst_io_reg;
            xl_off = ind_dst_off;
         end
         TME_DST_WR:
         begin
            xl_base = dst_ref_reg;
            xl_io = dst_io_reg;
            xl_off = dst_off;
         end
         default: xl_off = '0;
      endcase
   end

   // Indirect words are register numbers in register space
   wire use_ind_src = (state_reg == TME_SRC_RD) && ind_a_reg;
   wire use_ind_dst = (state_reg == TME_DST_WR) && ind_b_reg;
   wire ind_high = ind_addr_reg > REG_LIMIT;
   wire acc_high = (use_ind_src || use_ind_dst) ? ind_high : xl_high;
   wire acc_refused = acc_high && !high_ok;

   // Access address, direction and data
   always_comb
   begin
      acc_addr = (use_ind_src || use_ind_dst) ? ind_addr_reg : xl_addr;
      acc_we = (state_reg == TME_DST_WR) || (state_reg == TME_PTR_WR);
      acc_wdata = (state_reg == TME_PTR_WR) ? ptr_reg : st.out_data;
   end

   // Buffer handshakes: push on read return, pop on write return
   assign st.in_valid = (state_reg == TME_SRC_RD) && done_acc;
   assign st.in_data = mem_rdata;
   assign st.out_ready = ((state_reg == TME_DST_WR) && done_acc) || (state_reg == TME_FIN);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         TME_IDLE:
         begin
            if (start && fn_valid)
            begin
               if (tme_fn_e'(func_sel) == TME_FN_TBL_TO_TARGET_WORD_REF) state_next = TME_PTR_RD;
               else if (tme_fn_e'(func_sel) == TME_FN_EXTENDED && count_from_mem)
                  state_next = TME_CNT_RD;
               else state_next = TME_SEL;
            end
         end
         TME_CNT_RD: if (done_acc) state_next = TME_SEL;
         TME_PTR_RD: if (done_acc) state_next = TME_PTR_WR;
         TME_PTR_WR: if (done_acc) state_next = TME_SEL;
         TME_SEL:
         begin
            if (can_read) state_next = ind_a_reg ? TME_IND_A : TME_SRC_RD;
            else if (st.out_valid) state_next = ind_b_reg ? TME_IND_B : TME_DST_WR;
            else if (!writes_left) state_next = TME_FIN;
         end
         TME_IND_A: if (done_acc) state_next = TME_SRC_RD;
         TME_SRC_RD: if (done_acc) state_next = TME_SEL;
         TME_IND_B: if (done_acc) state_next = TME_DST_WR;
         TME_DST_WR: if (done_acc) state_next = TME_SEL;
         TME_FIN: if (!st.out_valid) state_next = TME_IDLE; // Drop words left by an abort
      endcase
      // A refused access ends the scan before touching memory
      if (issue && acc_refused && (state_reg inside {TME_PTR_RD, TME_SRC_RD, TME_DST_WR}))
         state_next = TME_FIN;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock)
   begin
      if (!reset_n) state_reg <= TME_IDLE;
      else state_reg <= state_next;
   end

   // Configuration capture at scan start
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         fn_reg <= TME_FN_NONE;
         src_ref_reg <= '0;
         dst_ref_reg <= '0;
         src_io_reg <= 1'b0;
         dst_io_reg <= 1'b0;
         ind_a_reg <= 1'b0;
         ind_b_reg <= 1'b0;
      end
      else if (start)
      begin
         fn_reg <= tme_fn_e'(func_sel);
         src_ref_reg <= source_block_ref;
         src_io_reg <= source_is_io;
         // Pointer copy writes one word, table copies a whole table
         dst_ref_reg <= (tme_fn_e'(func_sel) == TME_FN_TBL_TO_TARGET_WORD_REF) ?
            target_word_ref : target_block_ref;
         dst_io_reg <= (tme_fn_e'(func_sel) == TME_FN_TBL_TO_TARGET_WORD_REF) ?
            target_word_is_io : target_is_io;
         // Indirect only for extended copy on capable firmware
         ind_a_reg <= IND_OK && indirect_source &&
            (tme_fn_e'(func_sel) == TME_FN_EXTENDED);
         ind_b_reg <= IND_OK && indirect_target &&
            (tme_fn_e'(func_sel) == TME_FN_EXTENDED);
      end
   end

   // Transfer length and word indices
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         len_reg <= CNT_ZERO;
         rd_idx_reg <= CNT_ZERO;
         wr_idx_reg <= CNT_ZERO;
      end
      else
      begin
         if (start) len_reg <= word_count;
         else if (state_reg == TME_CNT_RD && done_acc) len_reg <= mem_count;
         if (state_reg == TME_PTR_WR && done_acc) len_reg <= CNT_ONE;
         if (start)
         begin
            rd_idx_reg <= CNT_ZERO;
            wr_idx_reg <= CNT_ZERO;
         end
         if (st.in_valid) rd_idx_reg <= rd_idx_reg + CNT_STEP;
         if (st.out_ready) wr_idx_reg <= wr_idx_reg + CNT_STEP;
      end
   end

   // Pointer value and indirect address holding
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         ptr_reg <= '0;
         ind_addr_reg <= '0;
      end
      else
      begin
         if (state_reg == TME_PTR_RD && done_acc) ptr_reg <= ptr_new;
         if ((state_reg == TME_IND_A || state_reg == TME_IND_B) && done_acc)
            ind_addr_reg <= mem_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory port: one access outstanding, request held until acknowledge
   wire mem_state = (state_reg == TME_CNT_RD) || (state_reg == TME_PTR_RD) ||
      (state_reg == TME_PTR_WR) || (state_reg == TME_IND_A) ||
      (state_reg == TME_SRC_RD) || (state_reg == TME_IND_B) ||
      (state_reg == TME_DST_WR);
   wire do_issue = mem_state && issue && !acc_refused;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_addr_reg <= '0;
         mem_wdata_reg <= '0;
      end
      else if (do_issue)
      begin
         mem_req_reg <= 1'b1;
         mem_we_reg <= acc_we;
         mem_addr_reg <= acc_addr;
         mem_wdata_reg <= acc_wdata;
      end
      else if (done_acc)
      begin
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power flow, fault and completion flags
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         power_flow_reg <= 1'b0;
         fault_reg <= 1'b0;
         scan_done_reg <= 1'b0;
      end
      else
      begin
         scan_done_reg <= (state_reg == TME_FIN) && (state_next == TME_IDLE);
         if (scan_tick && !rung_enable && state_reg == TME_IDLE)
            power_flow_reg <= 1'b0;
         if (start)
         begin
            fault_reg <= 1'b0;
            // Table copies flow whenever enabled
            power_flow_reg <= (tme_fn_e'(func_sel) == TME_FN_TBL_TO_TBL) ||
               (tme_fn_e'(func_sel) == TME_FN_EXTENDED);
         end
         if (state_reg == TME_PTR_RD && done_acc)
            power_flow_reg <= (ptr_new == WORD_W'(len_reg));
         if (mem_state && issue && acc_refused)
            fault_reg <= 1'b1;
      end
   end

   // Busy indication, registered
   logic busy_reg;
   always_ff @(posedge clock)
   begin
      if (!reset_n) busy_reg <= 1'b0;
      else busy_reg <= (state_next != TME_IDLE);
   end

   assign mem_req = mem_req_reg;
   assign mem_we = mem_we_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign power_flow = power_flow_reg;
   assign scan_done = scan_done_reg;
   assign busy = busy_reg;
   assign access_fault = fault_reg;
endmodule : tme_engine

// ### tme_engine_asserts.sv
// Port-level checks for the table move engine
`timescale 1ns/100ps
module tme_engine_asserts
   import tme_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic scan_tick,
   input wire logic rung_enable,
   input wire logic [1:0] func_sel,
   input wire logic expanded_opt,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [WORD_W-1:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic power_flow,
   input wire logic scan_done,
   input wire logic busy,
   input wire logic access_fault
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Accepted start strobes
   wire start_w = scan_tick && !busy;
   wire run_w = start_w && rung_enable && func_sel != 2'h3;
   ////////////////////////////////////////////////////////////////////////////////
   a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
      $stable(mem_we) && $stable(mem_wdata)) else $error("request changed before ack");
   a_req_end: assert property (mem_req && mem_ack |=> !mem_req) else $error("request kept after ack");
   a_req_busy: assert property (mem_req |-> busy) else $error("access while idle");
   a_done_pulse: assert property (scan_done |=> !scan_done) else $error("done too long");
   a_start_busy: assert property (run_w |=> busy && !access_fault) else $error("start not taken");
   a_done_bound: assert property (run_w |=> ##[1:400] scan_done) else $error("scan never ends");
   a_idle_off: assert property (start_w && !rung_enable |=> (!busy && !power_flow) [*2])
      else $error("disabled scan did work");
   a_table_flow: assert property (run_w && func_sel != 2'h0 |=> power_flow)
      else $error("table copy gave no power flow");
   a_flow_hold: assert property (!busy && !scan_tick |=> $stable(power_flow))
      else $error("power flow moved while idle");
   a_reg_limit: assert property (mem_req && func_sel != 2'h2 && !expanded_opt |->
      mem_addr <= REG_LIMIT || mem_addr >= IO_WORD_BASE) else $error("high register reached");
endmodule : tme_engine_asserts

bind tme_engine tme_engine_asserts u_chk (
   .clock(clock), .reset_n(reset_n), .scan_tick(scan_tick), .rung_enable(rung_enable),
   .func_sel(func_sel), .expanded_opt(expanded_opt), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .power_flow(power_flow),
   .scan_done(scan_done), .busy(busy), .access_fault(access_fault)
);

// ### tme_mem_model.sv
// Behavioural controller data memory on the engine's word port
`timescale 1ns/100ps
module tme_mem_model
   import tme_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [1:0] ack_delay,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [WORD_W-1:0] mem_wdata,
   output logic [WORD_W-1:0] mem_rdata,
   output logic mem_ack
);
   logic [WORD_W-1:0] mem [0:65535];
   logic [1:0] wait_reg;
   // Address-derived preload pattern
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 16'(i) ^ 16'h5A3C;
   end
   // One word per access, acked after ack_delay wait cycles
   always @(posedge clock)
   begin
      mem_rdata <= ~mem_rdata; // Stale data never lingers
      mem_ack <= 1'b0;
      if (!reset_n)
      begin
         wait_reg <= 2'h0;
         mem_rdata <= 16'h0000;
      end
      else if (mem_req && !mem_ack)
      begin
         if (wait_reg == ack_delay)
         begin
            mem_ack <= 1'b1;
            wait_reg <= 2'h0;
            mem_rdata <= mem[mem_addr];
            if (mem_we)
               mem[mem_addr] <= mem_wdata;
         end
         else
            wait_reg <= wait_reg + 2'h1;
      end
   end
endmodule : tme_mem_model

// ### test_tme_engine.sv
// Self-checking bench for the table move engine
`timescale 1ns/100ps
module test_tme_engine
   import tme_pkg::*;
;
   logic clock = 1'b0, reset_n = 1'b0, scan_tick = 1'b0, rung_enable = 1'b0;
   logic [1:0] func_sel = 2'h3, ack_delay = 2'h0;
   logic expanded_opt = 1'b0, source_is_io = 1'b0, target_is_io = 1'b0;
   logic target_word_is_io = 1'b0, count_from_mem = 1'b0, count_is_io = 1'b0;
   logic indirect_source = 1'b0, indirect_target = 1'b0;
   logic [ADDR_W-1:0] source_block_ref = 16'h0000, target_block_ref = 16'h0000;
   logic [ADDR_W-1:0] target_word_ref = 16'h0000, count_ref = 16'h0000;
   logic [CNT_W-1:0] word_count = 8'h00;
   logic mem_req, mem_we, mem_ack, power_flow, scan_done, busy, access_fault;
   logic [ADDR_W-1:0] mem_addr;
   logic [WORD_W-1:0] mem_wdata, mem_rdata;
   logic [31:0] wq [$];
   logic [1:0] fq [$];
   int n_fail = 0, n_compared = 0;
   integer seed = 32'h1940;

   tme_engine dut (.*);
   tme_mem_model u_mem (.*);

   // Clock, 40 ns period
   initial
   forever #20 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp16
   task automatic cmp1(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp1
   task automatic test_done;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // One scan started on a falling edge; pf bit 1 asks for a flow check
   task automatic run_scan(input logic [1:0] fn, input logic en, input logic [1:0] pf);
      int n;
      n = 0;
      @(negedge clock);
      func_sel = fn;
      rung_enable = en;
      ack_delay = 2'($random(seed));
      scan_tick = 1'b1;
      if (en && fn != 2'h3)
         fq.push_back(pf);
      @(negedge clock);
      scan_tick = 1'b0;
      if (en && fn != 2'h3)
      begin
         while (scan_done !== 1'b1 && n < 500)
         begin
            @(negedge clock);
            n++;
         end
         cmp1("scan done", 1'b1, scan_done);
         @(negedge clock);
      end
      else
         repeat (3) @(negedge clock);
      cmp16("writes pending", 16'h0000, 16'(wq.size()));
   endtask : run_scan
   // Pointer copy scan: pointer write-back then the selected entry
   task automatic ptr_scan(input logic [15:0] pw, input logic [15:0] tw);
      logic [15:0] p;
      p = u_mem.mem[pw] + PTR_STEP;
      if (p == 16'h0000 || p > 16'(word_count))
         p = PTR_FIRST;
      wq.push_back({pw, p});
      wq.push_back({tw, u_mem.mem[pw + p]});
      run_scan(2'h0, 1'b1, {1'b1, p == 16'(word_count)});
   endtask : ptr_scan
   // Whole table copy note; s and d give the final data addresses
   task automatic tbl_scan(input logic [1:0] fn, input logic [15:0] s, input logic [15:0] d,
      input int len);
      for (int i = 0; i < len; i++)
         wq.push_back({d + 16'(i), u_mem.mem[s + 16'(i)]});
      run_scan(fn, 1'b1, 2'h3);
   endtask : tbl_scan
   ////////////////////////////////////////////////////////////////////////////////
   // Compare completed writes and scan results with the oldest notes
   always @(posedge clock)
   begin
      if (mem_req && mem_we && mem_ack)
      begin
         if (wq.size() == 0)
            cmp1("write expected", 1'b0, 1'b1);
         else
         begin
            cmp16("write address", wq[0][31:16], mem_addr);
            cmp16("write data", wq[0][15:0], mem_wdata);
            void'(wq.pop_front());
         end
      end
      if (scan_done === 1'b1 && fq.size() > 0)
      begin
         if (fq[0][1])
            cmp1("power flow", fq[0][0], power_flow);
         void'(fq.pop_front());
      end
   end
   // Watchdog
   initial
   begin
      #(CLK_PERIOD_NS * 20000);
      n_fail++;
      test_done();
   end
   // Main sequence
   initial
   begin
      logic [15:0] s;
      int len;
      repeat (5) @(posedge clock);
      @(negedge clock);
      reset_n = 1'b1;
      source_block_ref = 16'h0100;
      target_word_ref = 16'h0200;
      word_count = 8'h03;
      for (int k = 0; k < 5; k++)
         ptr_scan(16'h0100, 16'h0200);
      source_is_io = 1'b1;
      source_block_ref = 16'h0011;
      target_word_is_io = 1'b1;
      target_word_ref = 16'h0081;
      word_count = 8'h02;
      for (int k = 0; k < 3; k++)
         ptr_scan(16'hC001, 16'hC008);
      source_is_io = 1'b0;
      $display("pointer copy test ended");
      for (int k = 0; k < 4; k++)
      begin
         len = 1 + $unsigned($random(seed)) % 6;
         s = 16'h0300 + 16'($unsigned($random(seed)) % 64);
         source_block_ref = s;
         target_is_io = k[0];
         target_block_ref = k[0] ? 16'h0041 : 16'h0380;
         word_count = 8'(len);
         tbl_scan(2'h1, s, k[0] ? 16'hC004 : 16'h0380, len);
         cmp16("source kept", s ^ 16'h5A3C, u_mem.mem[s]);
      end
      target_is_io = 1'b0;
      target_block_ref = 16'h0380;
      $display("table copy test ended");
      source_block_ref = 16'h0500;
      word_count = 8'h01;
      run_scan(2'h1, 1'b1, 2'h0);
      cmp1("access fault", 1'b1, access_fault);
      expanded_opt = 1'b1;
      tbl_scan(2'h1, 16'h0500, 16'h0380, 1);
      cmp1("access fault", 1'b0, access_fault);
      expanded_opt = 1'b0;
      $display("register limit test ended");
      for (int i = 0; i < 6; i++)
      begin
         u_mem.mem[16'h0600 + 16'(i)] = 16'h0800 + 16'(i);
         u_mem.mem[16'h0610 + 16'(i)] = 16'h0A00 + 16'(i);
      end
      u_mem.mem[16'hC002] = 16'h0006;
      count_ref = 16'h0021;
      count_is_io = 1'b1;
      count_from_mem = 1'b1;
      indirect_source = 1'b1;
      source_block_ref = 16'h0600;
      target_block_ref = 16'h0900;
      tbl_scan(2'h2, 16'h0800, 16'h0900, 6);
      count_from_mem = 1'b0;
      count_is_io = 1'b0;
      indirect_source = 1'b0;
      indirect_target = 1'b1;
      word_count = 8'h03;
      source_block_ref = 16'h0700;
      target_block_ref = 16'h0610;
      tbl_scan(2'h2, 16'h0700, 16'h0A00, 3);
      indirect_target = 1'b0;
      $display("extended copy test ended");
      run_scan(2'h1, 1'b0, 2'h0);
      cmp1("flow off", 1'b0, power_flow);
      cmp1("busy", 1'b0, busy);
      run_scan(2'h3, 1'b1, 2'h0);
      cmp1("busy", 1'b0, busy);
      $display("disabled scan test ended");
      test_done();
   end
endmodule : test_tme_engine
